// [common/adhc_params.svh]
/*
  Constants of the alarm, dwell and heat-cool decision block: register
  byte offsets, field positions, reset values, limits and timing.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef ADHC_PARAMS_SVH
`define ADHC_PARAMS_SVH

`define ADHC_OFS_CTRL       8'h00
`define ADHC_OFS_ALM_CFG    8'h04
`define ADHC_OFS_SETPOINT   8'h08
`define ADHC_OFS_HEAT_BAND  8'h0c
`define ADHC_OFS_GAP        8'h10
`define ADHC_OFS_COOL_RATIO 8'h14
`define ADHC_OFS_A1_THR     8'h18
`define ADHC_OFS_A1_HYS     8'h1c
`define ADHC_OFS_A1_OFS     8'h20
`define ADHC_OFS_A2_THR     8'h24
`define ADHC_OFS_A2_HYS     8'h28
`define ADHC_OFS_A2_OFS     8'h2c
`define ADHC_OFS_DWELL_TIME 8'h30
`define ADHC_OFS_STATUS     8'h34
`define ADHC_OFS_DWELL_CNT  8'h38
`define ADHC_OFS_COOL_BAND  8'h3c

`define ADHC_CTRL_OUTPUT1_ACTION_REV  0
`define ADHC_CTRL_OUTPUT2_FUNCTION_ALM  1
`define ADHC_CTRL_EVT_RST   2
`define ADHC_CFG_F1_LSB     0
`define ADHC_CFG_M1_LSB     4
`define ADHC_CFG_F2_LSB     8
`define ADHC_CFG_M2_LSB     12

`define ADHC_RST_CTRL       3'h1
`define ADHC_RST_RATIO      8'h64
`define ADHC_RST_HEAT_BAND  16'h00c8
`define ADHC_RST_HYS        16'h0001

`define ADHC_GAP_MIN        (-16'sd360)
`define ADHC_GAP_MAX        (16'sd360)
`define ADHC_GAP_SCALE      1000
`define ADHC_RATIO_MIN      8'h01
`define ADHC_RATIO_SCALE    100

`define ADHC_ERR_NONE       8'h00
`define ADHC_ERR_MISSING    8'h06
`define ADHC_ERR_DUAL_TIMER 8'h07

`define ADHC_CLK_KHZ        200000
`define ADHC_DWELL_TICK_MS  6000

`endif

// [common/adhc_pkg.sv]
/*
  Types of the alarm, dwell and heat-cool decision block.
  Assumes adhc_params.svh is on the include path.
*/
package adhc_pkg;
  `include "adhc_params.svh"

  typedef enum logic [3:0] {
    ADHC_FN_NONE, ADHC_FN_TIMER, ADHC_FN_MAIN_HIGH, ADHC_FN_MAIN_LOW,
    ADHC_FN_AUX_HIGH, ADHC_FN_AUX_LOW, ADHC_FN_EITHER_HIGH,
    ADHC_FN_EITHER_LOW, ADHC_FN_DIFF_HIGH, ADHC_FN_DIFF_LOW,
    ADHC_FN_DEV_HIGH, ADHC_FN_DEV_LOW
  } adhc_func_t;

  typedef enum logic [1:0] {
    ADHC_PLAIN, ADHC_STICKY, ADHC_HOLD, ADHC_COMBINED
  } adhc_mode_t;

  typedef enum logic [1:0] {
    ADHC_DW_IDLE, ADHC_DW_WAIT, ADHC_DW_COUNT, ADHC_DW_DONE
  } adhc_dwell_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } adhc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } adhc_apb_rsp_t;

  typedef struct packed {
    adhc_func_t         func;
    adhc_mode_t         mode;
    logic signed [15:0] thr;
    logic [15:0]        hys;
    logic signed [15:0] ofs;
  } adhc_alarm_cfg_t;

  typedef struct packed {
    adhc_apb_rsp_t          rsp;
    logic                   output1_action_reverse;
    logic                   output2_function_alarm;
    logic                   evt_reset_en;
    logic signed [15:0]     setpoint;
    logic [15:0]            heat_band;
    logic signed [15:0]     gap;
    logic [7:0]             ratio;
    adhc_alarm_cfg_t [1:0]  al;
    logic [15:0]            dwell_time;
    logic [15:0]            dwell_count;
    logic [31:0]            tick_cnt;
    adhc_dwell_t            dstate;
    logic                   reached;
    logic [2:0]             evt_sync;
    logic                   evt_level;
    logic [1:0]             cond;
    logic [1:0]             stick;
    logic [1:0]             alarm;
    logic                   output1_action;
    logic                   output2_function;
    logic [7:0]             err_code;
  } adhc_state_t;
endpackage

// [rtl/adhc_core.sv]
/*
  Heat-cool allocation, dwell timer and two process alarms with an APB
  register slave. Assumes one free-running pclk; process values come from
  converter logic on the same clock, the event input is an external pin.
*/
`timescale 1ns/1ps
`include "adhc_params.svh"

// What this block does
// - Output 2 in alarm-2 selection drives alarm 2, process or deviation.
// - Heat-cool gap accepted only within -36.0% to +36.0% of heat band.
// - Negative gap: heat and cool both active across the overlap.
// - Positive gap: heat and cool both inactive across the dead band.
// - Cool band ratio is a percent of heat band, accepted 1 to 255.
// - Tuning never rewrites the cool band ratio.
// - Both channels on timer shows error code 7; the write is accepted and the dwell timer stays idle.
// - Dwell time held in tenths of a minute, 0 to 6553.5 minutes.
// - Dwell count starts from zero once main value first reaches setpoint.
// - Timer output keeps its initial state until time-out.
// - A timer channel ignores its alarm mode.
// - Output 2 as alarm 2 with alarm 2 function none shows error 6.
// - Eight process functions: high/low on main, aux, either, difference.
// - Either-value functions alarm when main or aux crosses the level.
// - Difference functions compare main minus aux with the level.
// - Process thresholds are alarm threshold plus and minus half hysteresis.
// - Plain mode: output follows the alarm condition.
// - Sticky mode: output stays energized after the condition clears.
// - Sticky output clears only on reset or enabled event input.
// - Hold mode blocks alarms until the setpoint is first reached.
// - Combined mode applies both hold and sticky behaviour.
// - Alarm 2 behaves as alarm 1 with its own parameters.
// - Deviation thresholds: setpoint plus offset, plus/minus half hysteresis.
module adhc_core
  import adhc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES =
    `ADHC_DWELL_TICK_MS * `ADHC_CLK_KHZ  // Cycles per 0.1 minute.
) (
  input  wire logic                pclk,              // Clock, 200 MHz.
  input  wire logic                presetn,           // Async reset, low.
  input  wire adhc_pkg::adhc_apb_req_t apb_req,       // APB request.
  output      adhc_pkg::adhc_apb_rsp_t apb_rsp,       // APB response.
  input  wire logic signed [15:0]  main_process_value, // Main value.
  input  wire logic signed [15:0]  aux_process_value,  // Auxiliary value.
  input  wire logic                event_input,       // Event pin, high.
  output      logic                output1_drive,     // Output 1 energized.
  output      logic                output2_drive,     // Output 2 energized.
  output      logic                alarm1_drive,      // Alarm 1 energized.
  output      logic [7:0]          error_code         // Displayed error.
);
  import adhc_pkg::*;

  adhc_state_t s;
  adhc_state_t next_s;

  function automatic logic is_timer(input adhc_func_t f);
    return f == ADHC_FN_TIMER;
  endfunction

  // Hysteretic comparison; prev is the condition held from the last cycle.
  function automatic logic eval_alarm(input adhc_alarm_cfg_t c,
                                      input logic prev,
                                      input logic signed [17:0] pv_main,
                                      input logic signed [17:0] pv_aux,
                                      input logic signed [17:0] sp);
    logic signed [17:0] base;
    logic signed [17:0] half;
    logic signed [17:0] hi;
    logic signed [17:0] lo;
    logic signed [17:0] v;
    logic               high_type;
    base = 18'sd0;
    half = $signed({3'b000, c.hys[15:1]});
    v    = pv_main;
    high_type = 1'b1;
    if (c.func == ADHC_FN_DEV_HIGH || c.func == ADHC_FN_DEV_LOW) begin
      base = sp + 18'(c.ofs);
    end else begin
      base = 18'(c.thr);
    end
    hi = base + half;
    lo = base - half;
    case (c.func)
      ADHC_FN_MAIN_HIGH:   v = pv_main;
      ADHC_FN_MAIN_LOW:    begin v = pv_main; high_type = 1'b0; end
      ADHC_FN_AUX_HIGH:    v = pv_aux;
      ADHC_FN_AUX_LOW:     begin v = pv_aux; high_type = 1'b0; end
      ADHC_FN_EITHER_HIGH: v = (pv_main > pv_aux) ? pv_main : pv_aux;
      ADHC_FN_EITHER_LOW:  begin
        v = (pv_main < pv_aux) ? pv_main : pv_aux;
        high_type = 1'b0;
      end
      ADHC_FN_DIFF_HIGH:   v = pv_main - pv_aux;
      ADHC_FN_DIFF_LOW:    begin v = pv_main - pv_aux; high_type = 1'b0; end
      ADHC_FN_DEV_HIGH:    v = pv_main;
      ADHC_FN_DEV_LOW:     begin v = pv_main; high_type = 1'b0; end
      default:             return 1'b0;
    endcase
    if (high_type) begin
      return prev ? !(v < lo) : (v > hi);
    end
    return prev ? !(v > hi) : (v < lo);
  endfunction

  logic signed [17:0] pv_m;
  logic signed [17:0] pv_a;
  logic signed [17:0] sp_w;
  logic signed [35:0] gap_prod;
  logic signed [17:0] gap_half;
  logic [23:0]        cool_band;
  logic               dual_timer;
  logic               timer_ok;
  logic               heat_on;
  logic               cool_on;
  logic               wr;
  logic               rd_cyc;
  logic               sticky_clr;
  logic [31:0]        rdata;
  logic               rerr;
  logic signed [15:0] wgap;

  assign pv_m = 18'(main_process_value);
  assign pv_a = 18'(aux_process_value);
  assign sp_w = 18'(s.setpoint);
  assign gap_prod = 36'($signed({1'b0, s.heat_band}) * s.gap);
  assign gap_half = 18'((gap_prod / `ADHC_GAP_SCALE) >>> 1);
  assign cool_band = 24'((s.heat_band * s.ratio) / `ADHC_RATIO_SCALE);
  assign dual_timer = is_timer(s.al[0].func) && is_timer(s.al[1].func);
  assign timer_ok = !dual_timer &&
                    (is_timer(s.al[0].func) || is_timer(s.al[1].func));
  // A signed gap moves both edges: negative overlaps, positive separates.
  assign heat_on = pv_m < (sp_w - gap_half);
  assign cool_on = pv_m > (sp_w + gap_half);
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite &&
              s.rsp.pready;
  assign rd_cyc = apb_req.psel && apb_req.penable && !s.rsp.pready;
  assign sticky_clr = s.evt_level && s.evt_reset_en;
  assign wgap = apb_req.pwdata[15:0];

  // Read data and error are prepared a cycle ahead so they leave a flop.
  always_comb begin
    rdata = 32'h0;
    rerr  = 1'b0;
    if (apb_req.paddr == `ADHC_OFS_CTRL) begin
      rdata = {29'h0, s.evt_reset_en, s.output2_function_alarm, s.output1_action_reverse};
    end else if (apb_req.paddr == `ADHC_OFS_ALM_CFG) begin
      rdata = {18'h0, s.al[1].mode, s.al[1].func, 2'b00, s.al[0].mode,
               s.al[0].func};
    end else if (apb_req.paddr == `ADHC_OFS_SETPOINT) begin
      rdata = {16'h0, s.setpoint};
    end else if (apb_req.paddr == `ADHC_OFS_HEAT_BAND) begin
      rdata = {16'h0, s.heat_band};
    end else if (apb_req.paddr == `ADHC_OFS_GAP) begin
      rdata = {16'h0, s.gap};
    end else if (apb_req.paddr == `ADHC_OFS_COOL_RATIO) begin
      rdata = {24'h0, s.ratio};
    end else if (apb_req.paddr == `ADHC_OFS_A1_THR) begin
      rdata = {16'h0, s.al[0].thr};
    end else if (apb_req.paddr == `ADHC_OFS_A1_HYS) begin
      rdata = {16'h0, s.al[0].hys};
    end else if (apb_req.paddr == `ADHC_OFS_A1_OFS) begin
      rdata = {16'h0, s.al[0].ofs};
    end else if (apb_req.paddr == `ADHC_OFS_A2_THR) begin
      rdata = {16'h0, s.al[1].thr};
    end else if (apb_req.paddr == `ADHC_OFS_A2_HYS) begin
      rdata = {16'h0, s.al[1].hys};
    end else if (apb_req.paddr == `ADHC_OFS_A2_OFS) begin
      rdata = {16'h0, s.al[1].ofs};
    end else if (apb_req.paddr == `ADHC_OFS_DWELL_TIME) begin
      rdata = {16'h0, s.dwell_time};
    end else if (apb_req.paddr == `ADHC_OFS_STATUS) begin
      rdata = {14'h0, s.dstate, s.err_code, 3'h0, s.reached, s.alarm,
               s.output2_function, s.output1_action};
    end else if (apb_req.paddr == `ADHC_OFS_DWELL_CNT) begin
      rdata = {16'h0, s.dwell_count};
    end else if (apb_req.paddr == `ADHC_OFS_COOL_BAND) begin
      rdata = {8'h0, cool_band};
    end else begin
      rerr = 1'b1;
    end
    if (apb_req.pwrite) begin
      rdata = 32'h0;
      if (apb_req.paddr == `ADHC_OFS_GAP &&
          (wgap < `ADHC_GAP_MIN || wgap > `ADHC_GAP_MAX)) begin
        rerr = 1'b1;
      end else if (apb_req.paddr == `ADHC_OFS_COOL_RATIO &&
                   apb_req.pwdata[7:0] < `ADHC_RATIO_MIN) begin
        rerr = 1'b1;
      end else if (apb_req.paddr == `ADHC_OFS_STATUS ||
                   apb_req.paddr == `ADHC_OFS_DWELL_CNT ||
                   apb_req.paddr == `ADHC_OFS_COOL_BAND) begin
        rerr = 1'b1;
      end
    end
  end

  always_comb begin
    next_s = s;
    next_s.rsp.pready  = rd_cyc;
    next_s.rsp.pslverr = rd_cyc ? rerr : 1'b0;
    next_s.rsp.prdata  = rd_cyc ? rdata : 32'h0;

    // Refused writes (pslverr set) leave every register as it was.
    if (wr && !s.rsp.pslverr) begin
      if (apb_req.paddr == `ADHC_OFS_CTRL) begin
        next_s.output1_action_reverse = apb_req.pwdata[`ADHC_CTRL_OUTPUT1_ACTION_REV];
        next_s.output2_function_alarm   = apb_req.pwdata[`ADHC_CTRL_OUTPUT2_FUNCTION_ALM];
        next_s.evt_reset_en = apb_req.pwdata[`ADHC_CTRL_EVT_RST];
      end else if (apb_req.paddr == `ADHC_OFS_ALM_CFG) begin
        next_s.al[0].func = adhc_func_t'(apb_req.pwdata[`ADHC_CFG_F1_LSB+:4]);
        next_s.al[0].mode = adhc_mode_t'(apb_req.pwdata[`ADHC_CFG_M1_LSB+:2]);
        next_s.al[1].func = adhc_func_t'(apb_req.pwdata[`ADHC_CFG_F2_LSB+:4]);
        next_s.al[1].mode = adhc_mode_t'(apb_req.pwdata[`ADHC_CFG_M2_LSB+:2]);
      end else if (apb_req.paddr == `ADHC_OFS_SETPOINT) begin
        next_s.setpoint = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == `ADHC_OFS_HEAT_BAND) begin
        next_s.heat_band = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == `ADHC_OFS_GAP) begin
        next_s.gap = wgap;
      end else if (apb_req.paddr == `ADHC_OFS_COOL_RATIO) begin
        // Only software reaches this field; tuning has no write path.
        next_s.ratio = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == `ADHC_OFS_A1_THR) begin
        next_s.al[0].thr = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == `ADHC_OFS_A1_HYS) begin
        next_s.al[0].hys = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == `ADHC_OFS_A1_OFS) begin
        next_s.al[0].ofs = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == `ADHC_OFS_A2_THR) begin
        next_s.al[1].thr = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == `ADHC_OFS_A2_HYS) begin
        next_s.al[1].hys = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == `ADHC_OFS_A2_OFS) begin
        next_s.al[1].ofs = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == `ADHC_OFS_DWELL_TIME) begin
        next_s.dwell_time = apb_req.pwdata[15:0];
      end
    end

    // Event pin: counts only once the second and third stages agree.
    next_s.evt_sync = {s.evt_sync[1:0], event_input};
    if (s.evt_sync[2] == s.evt_sync[1]) begin
      next_s.evt_level = s.evt_sync[2];
    end

    if (s.output1_action_reverse ? (pv_m >= sp_w) : (pv_m <= sp_w)) begin
      next_s.reached = 1'b1;
    end

    // Dwell timer; a dual-timer setup is written without pslverr but never starts.
    next_s.tick_cnt = s.tick_cnt;
    case (s.dstate)
      ADHC_DW_IDLE: begin
        if (timer_ok) begin
          next_s.dstate = ADHC_DW_WAIT;
        end
      end
      ADHC_DW_WAIT: begin
        if (!timer_ok) begin
          next_s.dstate = ADHC_DW_IDLE;
        end else if (s.reached) begin
          next_s.dwell_count = 16'h0;
          next_s.tick_cnt    = 32'h0;
          next_s.dstate      = ADHC_DW_COUNT;
        end
      end
      ADHC_DW_COUNT: begin
        if (!timer_ok) begin
          next_s.dstate = ADHC_DW_IDLE;
        end else if (s.dwell_count >= s.dwell_time) begin
          next_s.dstate = ADHC_DW_DONE;
        end else if (s.tick_cnt == 32'(TICK_CYCLES - 1)) begin
          next_s.tick_cnt    = 32'h0;
          next_s.dwell_count = s.dwell_count + 16'h1;
        end else begin
          next_s.tick_cnt = s.tick_cnt + 32'h1;
        end
      end
      default: begin
        // Count holds at its final value; state drops to idle once no valid timer setup remains.
        if (!timer_ok) begin
          next_s.dstate = ADHC_DW_IDLE;
        end
      end
    endcase

    for (int i = 0; i < 2; i++) begin
      next_s.cond[i] = eval_alarm(s.al[i], s.cond[i], pv_m, pv_a, sp_w);
      if (is_timer(s.al[i].func)) begin
        // Mode ignored; output changes only at time-out.
        next_s.alarm[i] = timer_ok && s.dstate == ADHC_DW_DONE;
        next_s.stick[i] = 1'b0;
      end else begin
        case (s.al[i].mode)
          ADHC_PLAIN: begin
            next_s.alarm[i] = s.cond[i];
            next_s.stick[i] = 1'b0;
          end
          ADHC_STICKY: begin
            // A fresh condition wins over a clear in the same cycle.
            next_s.stick[i] = (s.stick[i] & ~sticky_clr) | s.cond[i];
            next_s.alarm[i] = next_s.stick[i];
          end
          ADHC_HOLD: begin
            next_s.alarm[i] = s.cond[i] && s.reached;
            next_s.stick[i] = 1'b0;
          end
          default: begin
            next_s.stick[i] = (s.stick[i] & ~sticky_clr) |
                              (s.cond[i] & s.reached);
            next_s.alarm[i] = next_s.stick[i];
          end
        endcase
      end
    end

    if (dual_timer) begin
      next_s.err_code = `ADHC_ERR_DUAL_TIMER;
    end else if (s.output2_function_alarm && s.al[1].func == ADHC_FN_NONE) begin
      next_s.err_code = `ADHC_ERR_MISSING;
    end else begin
      next_s.err_code = `ADHC_ERR_NONE;
    end

    next_s.output1_action = s.output1_action_reverse ? heat_on : cool_on;
    next_s.output2_function = s.output2_function_alarm ? s.alarm[1] : cool_on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s              <= '0;
      {s.evt_reset_en, s.output2_function_alarm, s.output1_action_reverse} <= `ADHC_RST_CTRL;
      s.heat_band    <= `ADHC_RST_HEAT_BAND;
      s.ratio        <= `ADHC_RST_RATIO;
      s.al[0].hys    <= `ADHC_RST_HYS;
      s.al[1].hys    <= `ADHC_RST_HYS;
      s.dstate       <= ADHC_DW_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp       = s.rsp;
  assign output1_drive = s.output1_action;
  assign output2_drive = s.output2_function;
  assign alarm1_drive  = s.alarm[0];
  assign error_code    = s.err_code;
endmodule

// [testbench/adhc_core_chk.sv]
/*
  Port-level assertions for adhc_core.
  Assumes it is bound to the core and sees only the core's ports.
*/
`timescale 1ns/1ps
module adhc_core_chk
  import adhc_pkg::*;
(
  input wire logic                    pclk,               // Clock.
  input wire logic                    presetn,            // Reset, low.
  input wire adhc_pkg::adhc_apb_req_t apb_req,            // APB request.
  input wire adhc_pkg::adhc_apb_rsp_t apb_rsp,            // APB response.
  input wire logic signed [15:0]      main_process_value, // Main value.
  input wire logic                    output1_drive,      // Output 1.
  input wire logic [7:0]              error_code          // Error shown.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic               wr_done;
  logic [2:0]         cfg_quiet;
  logic [2:0]         pv_quiet;
  logic signed [15:0] last_pv;

  assign wr_done = apb_req.psel && apb_req.penable && apb_rsp.pready
                   && apb_req.pwrite;

  // Quiet counters saturate so a long idle spell cannot wrap to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_quiet <= 3'h0;
      pv_quiet  <= 3'h0;
      last_pv   <= 16'h0;
    end else begin
      last_pv   <= main_process_value;
      cfg_quiet <= wr_done ? 3'h0 : cfg_quiet + 3'(cfg_quiet != 3'h7);
      pv_quiet  <= (wr_done || main_process_value != last_pv) ? 3'h0 :
                   pv_quiet + 3'(pv_quiet != 3'h7);
    end
  end

  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready stood longer than one cycle");
  a_ready_late: assert property ((apb_req.psel && !apb_req.penable)
    |=> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("pready not in second access cycle");
  a_ready_access: assert property (apb_rsp.pready
    |-> apb_req.psel && apb_req.penable)
    else $error("pready outside an access phase");
  a_slverr_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  a_rsp_idle: assert property (!apb_rsp.pready
    |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
    else $error("response not zero outside pready");
  a_err_codes: assert property (error_code inside {8'h00, 8'h06, 8'h07})
    else $error("unknown error code shown");
  a_err_steady: assert property (cfg_quiet >= 3'h3 |-> $stable(error_code))
    else $error("error code moved without a write");
  a_heat_steady: assert property (pv_quiet >= 3'h4 |-> $stable(output1_drive))
    else $error("output 1 moved with steady inputs");
endmodule

// [testbench/adhc_plant.sv]
/*
  Sensor model: presents the process values to the core.
  Assumes the bench moves the process; readings lag one clock.
*/
`timescale 1ns/1ps
module adhc_plant (
  input  wire logic               pclk,     // Clock.
  input  wire logic signed [15:0] main_set, // Main process level.
  input  wire logic signed [15:0] aux_set,  // Auxiliary level.
  output      logic signed [15:0] main_pv,  // Main reading.
  output      logic signed [15:0] aux_pv    // Auxiliary reading.
);
  // A converter lag keeps readings off the edge the bench drives.
  always_ff @(posedge pclk) begin
    main_pv <= main_set;
    aux_pv  <= aux_set;
  end
endmodule

// [testbench/adhc_core_test.sv]
/*
  Self-checking bench for adhc_core: APB master, sensor model, one
  task per scenario. Assumes the dwell tick is shortened to 4 cycles.
*/
`timescale 1ns/1ps
`include "adhc_params.svh"
module adhc_core_test;
  import adhc_pkg::*;
  logic               pclk;
  logic               presetn;
  adhc_apb_req_t      req;
  adhc_apb_rsp_t      rsp;
  logic signed [15:0] main_set;
  logic signed [15:0] aux_set;
  logic signed [15:0] main_pv;
  logic signed [15:0] aux_pv;
  logic               evt;
  logic               o1;
  logic               o2;
  logic               a1;
  logic [7:0]         err;
  int                 n_fail;
  int                 compares;
  logic [31:0]        rdat;
  logic               rerr;
  int fc [13] = '{2, 2, 2, 3, 4, 5, 6, 7, 8, 9, 9, 10, 11};
  int vm [13] = '{511, 495, 489, 400, 400, 400, 400, 400, 1200, 1200,
                  1000, 1200, 1200};
  int va [13] = '{0, 0, 0, 600, 600, 600, 600, 600, 600, 600, 600, 0, 0};
  localparam logic [12:0] EX = 13'h0ddb;

  adhc_plant i_adhc_plant (.pclk(pclk), .main_set(main_set),
    .aux_set(aux_set), .main_pv(main_pv), .aux_pv(aux_pv));
  adhc_core #(.TICK_CYCLES(4)) i_adhc_core (.pclk(pclk),
    .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .main_process_value(main_pv), .aux_process_value(aux_pv),
    .event_input(evt), .output1_drive(o1), .output2_drive(o2),
    .alarm1_drive(a1), .error_code(err));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is sampled high at a rising edge; the answer
  // is taken and the request released at that same edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    chk(32'(n < 20), 32'h1);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdat, x);
  endtask

  task automatic pv(input int m, input int a);
    @(posedge pclk);
    main_set <= 16'(m);
    aux_set  <= 16'(a);
  endtask

  task automatic settle();
    repeat (6) @(negedge pclk);
  endtask

  task automatic pulse_evt();
    @(posedge pclk);
    evt <= 1'b1;
    settle();
    @(posedge pclk);
    evt <= 1'b0;
    settle();
  endtask

  task automatic t_regs();
    rd(`ADHC_OFS_CTRL, 32'h1);
    rd(`ADHC_OFS_HEAT_BAND, 32'hc8);
    rd(`ADHC_OFS_COOL_RATIO, 32'h64);
    rd(`ADHC_OFS_COOL_BAND, 32'hc8);
    rd(`ADHC_OFS_A1_HYS, 32'h1);
    rd(8'h40, 32'h0);
    chk(rerr, 1'b1);
  endtask

  task automatic t_hold();
    apb(1'b1, `ADHC_OFS_SETPOINT, 32'h3e8);
    apb(1'b1, `ADHC_OFS_A1_THR, 32'h1f4);
    apb(1'b1, `ADHC_OFS_ALM_CFG, 32'h22);
    pv(600, 0);
    settle();
    chk(a1, 1'b0);
    pv(1000, 0);
    settle();
    chk(a1, 1'b1);
  endtask

  task automatic t_heatcool();
    apb(1'b1, `ADHC_OFS_GAP, 32'hff9c);
    settle();
    chk({o1, o2}, 2'b11);
    apb(1'b1, `ADHC_OFS_GAP, 32'h64);
    settle();
    chk({o1, o2}, 2'b00);
    pv(989, 0);
    settle();
    chk({o1, o2}, 2'b10);
    pv(1011, 0);
    settle();
    chk({o1, o2}, 2'b01);
    apb(1'b1, `ADHC_OFS_GAP, 32'h169);
    chk(rerr, 1'b1);
    rd(`ADHC_OFS_GAP, 32'h64);
    apb(1'b1, `ADHC_OFS_GAP, 32'hfe98);
    chk(rerr, 1'b0);
    apb(1'b1, `ADHC_OFS_COOL_RATIO, 32'h0);
    chk(rerr, 1'b1);
    apb(1'b1, `ADHC_OFS_COOL_RATIO, 32'hff);
    rd(`ADHC_OFS_COOL_BAND, 32'h1fe);
  endtask

  task automatic t_errors();
    apb(1'b1, `ADHC_OFS_ALM_CFG, 32'h101);
    settle();
    chk(err, 8'h07);
    apb(1'b1, `ADHC_OFS_CTRL, 32'h3);
    apb(1'b1, `ADHC_OFS_ALM_CFG, 32'h2);
    settle();
    chk(err, 8'h06);
    apb(1'b1, `ADHC_OFS_ALM_CFG, 32'h202);
    settle();
    chk(err, 8'h00);
  endtask

  task automatic t_alarms();
    for (int ch = 0; ch < 2; ch++) begin
      apb(1'b1, `ADHC_OFS_CTRL, 32'(1 + 2 * ch));
      apb(1'b1, ch ? `ADHC_OFS_A2_THR : `ADHC_OFS_A1_THR, 32'h1f4);
      apb(1'b1, ch ? `ADHC_OFS_A2_HYS : `ADHC_OFS_A1_HYS, 32'h14);
      for (int i = 0; i < 13; i++) begin
        apb(1'b1, `ADHC_OFS_ALM_CFG, 32'(fc[i]) << (8 * ch));
        pv(vm[i], va[i]);
        settle();
        chk(ch ? o2 : a1, EX[i]);
      end
    end
  endtask

  task automatic t_sticky();
    apb(1'b1, `ADHC_OFS_CTRL, 32'h1);
    for (int m = 1; m < 4; m += 2) begin
      apb(1'b1, `ADHC_OFS_ALM_CFG, 32'(m * 16 + 2));
      pv(511, 0);
      settle();
      pv(0, 0);
      pulse_evt();
      chk(a1, 1'b1);
      apb(1'b1, `ADHC_OFS_CTRL, 32'h5);
      pulse_evt();
      chk(a1, 1'b0);
      apb(1'b1, `ADHC_OFS_CTRL, 32'h1);
    end
  endtask

  task automatic t_dwell();
    int n;
    apb(1'b1, `ADHC_OFS_DWELL_TIME, 32'hffff);
    rd(`ADHC_OFS_DWELL_TIME, 32'hffff);
    apb(1'b1, `ADHC_OFS_DWELL_TIME, 32'h3);
    apb(1'b1, `ADHC_OFS_SETPOINT, 32'h3e8);
    apb(1'b1, `ADHC_OFS_ALM_CFG, 32'h11);
    settle();
    rd(`ADHC_OFS_DWELL_CNT, 32'h0);
    chk(a1, 1'b0);
    pv(1000, 0);
    n = 0;
    while (a1 !== 1'b1 && n < 60) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n inside {[9:20]}), 32'h1);
    pv(-100, 0);
    settle();
    chk(a1, 1'b1);
    rd(`ADHC_OFS_DWELL_CNT, 32'h3);
  endtask

  // Reset with the process below set point so nothing counts as reached.
  task automatic do_reset();
    @(posedge pclk);
    presetn  <= 1'b0;
    main_set <= -16'sd100;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial begin
    n_fail   = 0;
    compares = 0;
    req      = '0;
    evt      = 1'b0;
    presetn  = 1'b0;
    main_set = -16'sd100;
    aux_set  = 16'sd0;
    do_reset();
    t_regs();
    t_hold();
    t_heatcool();
    t_errors();
    t_alarms();
    t_sticky();
    do_reset();
    t_dwell();
    print_verdict();
  end

  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
endmodule

bind adhc_core adhc_core_chk i_adhc_core_chk (.pclk(pclk),
  .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .main_process_value(main_process_value),
  .output1_drive(output1_drive), .error_code(error_code));
